// [core/fault_diag_autoretry.sv]
// Fault protection, auto-retry and diagnostic manager for a four-output high-side switch
`timescale 1ns/1ps
`include "fault_diag_defs.svh"
module fault_diag_autoretry
   import fault_diag_pkg::*;
#(
   parameter int NCH         = 4,
   parameter int T_AUTO_CYC  = `FD_T_AUTO_CYC,
   parameter int LED_CHECK_PERIOD_CYC = `FD_LED_CHECK_PERIOD_CYC,
   parameter int RETRY_LIMIT = `FD_RETRY_LIMIT
)(
   input  wire logic            clk,
   input  wire logic            rst_b,
   input  wire logic [NCH-1:0]  output_cmd,
   input  wire logic [NCH-1:0]  direct_input,
   input  wire logic [6:0]      duty_ch0,
   input  wire logic [6:0]      duty_ch1,
   input  wire logic [6:0]      duty_ch2,
   input  wire logic [6:0]      duty_ch3,
   input  wire logic            normal_mode,
   input  wire logic            extended_mode,
   input  wire logic            battery_uv,
   input  wire logic            battery_por,
   input  wire logic            logic_supply_fail,
   input  wire logic            supply_fail_enable,
   input  wire logic            overvoltage_det,
   input  wire logic            overvoltage_disable,
   input  wire logic            clamp_det,
   input  wire logic            temp_warning_det,
   input  wire logic [NCH-1:0]  overcurrent_det,
   input  wire logic [NCH-1:0]  overtemp_det,
   input  wire logic [NCH-1:0]  severe_short_det,
   input  wire logic [NCH-1:0]  short_supply_det,
   input  wire logic [NCH-1:0]  gate_low,
   input  wire logic [NCH-1:0]  open_load_off_det,
   input  wire logic [NCH-1:0]  open_load_on_det,
   input  wire logic [NCH-1:0]  short_detect_disable,
   input  wire logic [NCH-1:0]  open_load_off_disable,
   input  wire logic [NCH-1:0]  open_load_on_disable,
   input  wire logic [NCH-1:0]  led_open_load_select,
   input  wire logic [NCH-1:0]  retry_disable,
   input  wire feedback_cfg_s   feedback_cfg,
   input  wire logic            status_read,
   output logic [NCH-1:0]       high_side_output,
   output logic [NCH-1:0]       inrush_profile_restart,
   output logic                 fault_flag_n,
   output fault_report_s        diagnostic_register_zero,
   output feedback_route_s      analog_feedback_out,
   output logic                 regs_cleared
);

   ////////////////////////////////////////////////////////////////////
   // Supply conditions and mode transitions

   logic       normal_d_r;
   logic       por_d_r;
   logic       first_read_done_r;

   wire vdd_lost      = logic_supply_fail & supply_fail_enable;
   wire fault_wipe    = (logic_supply_fail & ~battery_uv) | battery_por;
   wire mode_change   = (normal_mode != normal_d_r);
   wire por_release   = por_d_r & ~battery_por;
   wire counter_clear = mode_change | battery_por | por_release;
   wire failsafe      = ~normal_mode | vdd_lost;

   // A read only clears the latches on the first transfer after they were shown
   wire read_clear    = status_read & ~first_read_done_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         normal_d_r        <= 1'b0;
         por_d_r           <= 1'b0;
         first_read_done_r <= 1'b0;
      end else begin
         normal_d_r <= normal_mode;
         por_d_r    <= battery_por;
         if (read_clear)
            first_read_done_r <= 1'b1;
         else if (~status_read)
            first_read_done_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Effective command: direct inputs take over when the logic supply is gone and supply_fail_enable is set

   wire [NCH-1:0] eff_cmd = vdd_lost ? direct_input : output_cmd;

   ////////////////////////////////////////////////////////////////////
   // Latched fault flags

   logic [NCH-1:0] oc_q;
   logic [NCH-1:0] ot_q;
   logic [NCH-1:0] sc_q;
   logic [NCH-1:0] os_q;
   logic [NCH-1:0] olf_q;
   logic [NCH-1:0] oln_q;
   logic [2:0]     misc_q;

   // Overtemperature still detected in extended mode above the uv threshold
   wire [NCH-1:0] ot_set  = overtemp_det & {NCH{~battery_uv}};
   wire [NCH-1:0] oc_set  = overcurrent_det & ~{NCH{extended_mode}};
   wire [NCH-1:0] os_live = short_supply_det & ~eff_cmd & ~short_detect_disable;
   wire [NCH-1:0] os_set  = os_live & gate_low;
   wire [NCH-1:0] olf_live = open_load_off_det & ~eff_cmd & ~open_load_off_disable;
   wire [NCH-1:0] olf_set = (olf_live & gate_low) | os_set;

   logic [NCH-1:0] on_time_done;
   logic [NCH-1:0] led_tick;
   wire  [6:0]     duty [NCH];
   assign duty[0] = duty_ch0;
   assign duty[1] = duty_ch1;
   assign duty[2] = duty_ch2;
   assign duty[3] = duty_ch3;

   logic [NCH-1:0] oln_check;
   logic [NCH-1:0] retry_req;
   logic [NCH-1:0] ch_enable;
   logic [NCH-1:0] ch_latched;
   logic [NCH-1:0] ch_inrush;

   localparam int LW = $clog2(LED_CHECK_PERIOD_CYC + 1);

   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         logic [LW-1:0] on_cnt_r;
         logic [LW-1:0] period_r;
         wire full_on = (duty[c] == `FD_DUTY_FULL);
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               on_cnt_r <= '0;
               period_r <= '0;
            end else begin
               if (!high_side_output[c] || !full_on)
                  on_cnt_r <= '0;
               else if (on_cnt_r != LW'(LED_CHECK_PERIOD_CYC))
                  on_cnt_r <= on_cnt_r + 1'b1;
               period_r <= (period_r == LW'(LED_CHECK_PERIOD_CYC - 1)) ? '0 : period_r + 1'b1;
            end
         end
         assign on_time_done[c] = (on_cnt_r == LW'(LED_CHECK_PERIOD_CYC));
         assign led_tick[c]     = (period_r == LW'(LED_CHECK_PERIOD_CYC - 1));
         // Bulb threshold checks continuously; LED only once per period when fully on
         assign oln_check[c] = high_side_output[c] & ~open_load_on_disable[c] &
                               (led_open_load_select[c] ?
                                (full_on & on_time_done[c] & led_tick[c]) : 1'b1);
         assign retry_req[c] = oc_q[c] | ot_q[c] | misc_q[0];

         retry_channel #(
            .T_AUTO_CYC  (T_AUTO_CYC),
            .RETRY_LIMIT (RETRY_LIMIT)
         ) u_retry (
            .clk            (clk),
            .rst_b          (rst_b),
            .cmd_on         (eff_cmd[c]),
            .retry_req      (retry_req[c] | sc_q[c]),
            .fault_now      (overcurrent_det[c] | overtemp_det[c] | battery_uv | sc_q[c]),
            .retry_enable   (~sc_q[c] & ~retry_disable[c] & ~vdd_lost),
            .counter_clear  (counter_clear),
            .out_enable     (ch_enable[c]),
            .inrush_restart (ch_inrush[c]),
            .latched_off    (ch_latched[c])
         );
      end
   endgenerate

   wire [NCH-1:0] oln_set = oln_check & open_load_on_det;

   flag_latch #(.W(NCH)) u_oc (
      .clk(clk), .rst_b(rst_b), .wipe(fault_wipe), .set_in(oc_set),
      .still_present(overcurrent_det), .read_clear(read_clear), .flag(oc_q)
   );
   flag_latch #(.W(NCH)) u_ot (
      .clk(clk), .rst_b(rst_b), .wipe(fault_wipe), .set_in(ot_set),
      .still_present(overtemp_det), .read_clear(read_clear), .flag(ot_q)
   );
   flag_latch #(.W(NCH)) u_sc (
      .clk(clk), .rst_b(rst_b), .wipe(fault_wipe), .set_in(severe_short_det),
      .still_present(severe_short_det), .read_clear(read_clear), .flag(sc_q)
   );
   flag_latch #(.W(NCH)) u_os (
      .clk(clk), .rst_b(rst_b), .wipe(battery_por), .set_in(os_set),
      .still_present(os_live), .read_clear(read_clear), .flag(os_q)
   );
   flag_latch #(.W(NCH)) u_olf (
      .clk(clk), .rst_b(rst_b), .wipe(battery_por), .set_in(olf_set),
      .still_present(olf_live | os_live | {NCH{~fault_flag_n}}),
      .read_clear(read_clear), .flag(olf_q)
   );
   flag_latch #(.W(NCH)) u_oln (
      .clk(clk), .rst_b(rst_b), .wipe(battery_por), .set_in(oln_set),
      .still_present(oln_set), .read_clear(read_clear), .flag(oln_q)
   );

   // Bit 0 undervoltage, bit 1 overvoltage, bit 2 temperature prewarning
   wire [2:0] misc_set  = {temp_warning_det & normal_mode, overvoltage_det, battery_uv};
   wire [2:0] misc_live = {1'b0, overvoltage_det, battery_uv | (|(eff_cmd & ch_latched))};
   flag_latch #(.W(3)) u_misc (
      .clk(clk), .rst_b(rst_b), .wipe(fault_wipe), .set_in(misc_set),
      .still_present(misc_live), .read_clear(read_clear), .flag(misc_q)
   );

   ////////////////////////////////////////////////////////////////////
   // Output drive and fault pin

   wire ov_block = overvoltage_det & ~overvoltage_disable;
   wire [NCH-1:0] hs_nxt = clamp_det ? {NCH{1'b1}} :
                           (ch_enable & eff_cmd & ~{NCH{battery_uv | battery_por | ov_block}});

   // Pin follows live off-state faults and latched shutdowns of commanded outputs
   wire fault_live = battery_uv | ov_block | (|overtemp_det) | (|(os_live & gate_low)) |
                     (|(olf_live & gate_low)) | (|(eff_cmd & ch_latched)) | (|sc_q);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         high_side_output       <= '0;
         inrush_profile_restart <= '0;
         fault_flag_n           <= 1'b1;
      end else begin
         high_side_output       <= hs_nxt;
         inrush_profile_restart <= ch_inrush;
         fault_flag_n           <= ~fault_live;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Report and analog feedback routing

   feedback_route_s route_nxt;
   wire [1:0] sel        = feedback_cfg.sense_output_select;
   wire       sel_on     = high_side_output[sel];
   wire       curr_ok    = feedback_cfg.current_sense_enable & ~failsafe & sel_on;

   always_comb begin
      route_nxt.channel    = sel;
      route_nxt.high_ratio = feedback_cfg.sense_ratio_select[sel];
      if (feedback_cfg.temp_enable)
         route_nxt.source = `FD_FB_SEL_TEMP;
      else if (curr_ok)
         route_nxt.source = `FD_FB_SEL_CURR;
      else
         route_nxt.source = `FD_FB_SEL_NONE;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         diagnostic_register_zero <= '0;
         analog_feedback_out      <= '0;
         regs_cleared             <= 1'b0;
      end else begin
         diagnostic_register_zero <= {oc_q, ot_q, sc_q, os_q, olf_q, oln_q,
                                      misc_q[0], misc_q[1], misc_q[2]};
         analog_feedback_out      <= route_nxt;
         regs_cleared             <= vdd_lost | battery_por;
      end
   end

endmodule

// [core/fault_diag_defs.svh]
// Timing counts, limits and reset values for the fault and diagnostic manager
`ifndef FAULT_DIAG_DEFS_SVH
`define FAULT_DIAG_DEFS_SVH

`define FD_CLK_PERIOD_NS      10
`define FD_T_AUTO_US          1000
`define FD_T_AUTO_CYC         ((`FD_T_AUTO_US * 1000) / `FD_CLK_PERIOD_NS)
`define FD_LED_CHECK_PERIOD_US         1000
`define FD_LED_CHECK_PERIOD_CYC        ((`FD_LED_CHECK_PERIOD_US * 1000) / `FD_CLK_PERIOD_NS)
`define FD_RETRY_LIMIT        16
`define FD_DUTY_FULL          7'h7F
`define FD_FLAGS_RST          4'h0
`define FD_FB_SEL_TEMP        2'h1
`define FD_FB_SEL_CURR        2'h2
`define FD_FB_SEL_NONE        2'h0

`endif

// [core/fault_diag_pkg.sv]
// Types shared by the fault and diagnostic manager
package fault_diag_pkg;

   typedef enum logic [1:0] {
      CH_IDLE    = 2'b00,
      CH_ON      = 2'b01,
      CH_WAIT    = 2'b10,
      CH_LOCKED  = 2'b11
   } ch_state_e;

   typedef struct packed {
      logic [3:0] overcurrent_flag;
      logic [3:0] overtemp_flag;
      logic [3:0] severe_short_flag;
      logic [3:0] short_to_supply_flag;
      logic [3:0] open_load_off_flag;
      logic [3:0] open_load_on_flag;
      logic       undervoltage_flag;
      logic       overvoltage_flag;
      logic       temp_prewarning_flag;
   } fault_report_s;

   typedef struct packed {
      logic       temp_enable;
      logic       current_sense_enable;
      logic [1:0] sense_output_select;
      logic [3:0] sense_ratio_select;
   } feedback_cfg_s;

   typedef struct packed {
      logic [1:0] source;
      logic [1:0] channel;
      logic       high_ratio;
   } feedback_route_s;

endpackage

// [core/retry_channel.sv]
// Per-output auto-retry state machine with occurrence counter
`timescale 1ns/1ps
`include "fault_diag_defs.svh"
module retry_channel
   import fault_diag_pkg::*;
#(
   parameter int T_AUTO_CYC  = `FD_T_AUTO_CYC,
   parameter int RETRY_LIMIT = `FD_RETRY_LIMIT
)(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic cmd_on,
   input  wire logic retry_req,
   input  wire logic fault_now,
   input  wire logic retry_enable,
   input  wire logic counter_clear,
   output logic      out_enable,
   output logic      inrush_restart,
   output logic      latched_off
);

   localparam int CW = $clog2(T_AUTO_CYC + 1);
   localparam int RW = $clog2(RETRY_LIMIT + 1);

   ch_state_e       state_r;
   ch_state_e       state_nxt;
   logic [CW-1:0]   timer_r;
   logic [RW-1:0]   tries_r;
   logic            cmd_d_r;

   wire cmd_rise     = cmd_on & ~cmd_d_r;
   wire timer_done   = (timer_r == CW'(T_AUTO_CYC - 1));
   wire limit_hit    = (tries_r == RW'(RETRY_LIMIT));
   wire retry_fire   = (state_r == CH_WAIT) & timer_done & ~fault_now;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CH_IDLE: begin
            if (cmd_on & ~retry_req)
               state_nxt = CH_ON;
         end
         CH_ON: begin
            if (!cmd_on)
               state_nxt = CH_IDLE;
            else if (retry_req)
               state_nxt = (retry_enable & ~limit_hit) ? CH_WAIT : CH_LOCKED;
         end
         CH_WAIT: begin
            if (!cmd_on)
               state_nxt = CH_IDLE;
            else if (retry_fire)
               state_nxt = CH_ON;
         end
         CH_LOCKED: begin
            if (cmd_rise | counter_clear)
               state_nxt = CH_IDLE;
         end
         default: state_nxt = CH_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= CH_IDLE;
         timer_r <= '0;
         tries_r <= '0;
         cmd_d_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cmd_d_r <= cmd_on;
         timer_r <= (state_r == CH_WAIT && !timer_done) ? timer_r + 1'b1 : '0;
         if (counter_clear || cmd_rise)
            tries_r <= '0;
         else if (retry_fire)
            tries_r <= tries_r + 1'b1;
      end
   end

   assign out_enable     = (state_r == CH_ON);
   assign inrush_restart = retry_fire | ((state_r == CH_IDLE) & (state_nxt == CH_ON));
   assign latched_off    = (state_r == CH_WAIT) | (state_r == CH_LOCKED);

endmodule

// [core/flag_latch.sv]
// Sticky flag bank: set wins over a read clear, read clear only when condition gone; wipe clears unconditionally
`timescale 1ns/1ps
module flag_latch #(
   parameter int W = 4
)(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         wipe,
   input  wire logic [W-1:0] set_in,
   input  wire logic [W-1:0] still_present,
   input  wire logic         read_clear,
   output logic      [W-1:0] flag
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b)
               flag[i] <= 1'b0;
            else if (wipe)
               flag[i] <= 1'b0;
            else if (set_in[i])
               flag[i] <= 1'b1;
            else if (read_clear && !still_present[i])
               flag[i] <= 1'b0;
         end
      end
   endgenerate

endmodule

// [bench/fault_diag_autoretry_sva.sv]
// Port-level assertions for the fault and diagnostic manager
`timescale 1ns/1ps
`include "fault_diag_defs.svh"
module fault_diag_autoretry_sva
   import fault_diag_pkg::*;
(
   input wire logic            clk,
   input wire logic            rst_b,
   input wire logic            normal_mode,
   input wire logic            battery_uv,
   input wire logic            battery_por,
   input wire logic            logic_supply_fail,
   input wire logic            clamp_det,
   input wire logic            temp_warning_det,
   input wire logic [3:0]      short_supply_det,
   input wire logic [3:0]      gate_low,
   input wire logic [3:0]      short_detect_disable,
   input wire logic [3:0]      high_side_output,
   input wire logic [3:0]      inrush_profile_restart,
   input wire logic            fault_flag_n,
   input wire fault_report_s   diagnostic_register_zero,
   input wire feedback_route_s analog_feedback_out,
   input wire logic            regs_cleared
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   property p_uv_off;
      battery_uv && !clamp_det && !logic_supply_fail |=> high_side_output == 4'h0;
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("outputs on under undervoltage");
   property p_uv_pin;
      battery_uv && !clamp_det && !battery_por && !logic_supply_fail |=> !fault_flag_n;
   endproperty
   a_uv_pin: assert property (p_uv_pin) else $error("fault pin high under undervoltage");
   property p_uv_flag;
      battery_uv && !battery_por |=> ##1 diagnostic_register_zero.undervoltage_flag;
   endproperty
   a_uv_flag: assert property (p_uv_flag) else $error("undervoltage bit not reported");
   property p_clamp_on;
      clamp_det |=> high_side_output == 4'hF;
   endproperty
   a_clamp_on: assert property (p_clamp_on) else $error("clamp did not force outputs on");
   property p_por_off;
      battery_por && !clamp_det |=> high_side_output == 4'h0 && regs_cleared;
   endproperty
   a_por_off: assert property (p_por_off) else $error("supply reset left outputs on");
   property p_restart_pulse;
      |inrush_profile_restart |=> (inrush_profile_restart & $past(inrush_profile_restart)) == 4'h0;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("inrush restart too long");
   property p_failsafe_recopy;
      !normal_mode |=> analog_feedback_out.source != `FD_FB_SEL_CURR;
   endproperty
   a_failsafe_recopy: assert property (p_failsafe_recopy) else $error("recopy in fail-safe");
   property p_prewarn;
      normal_mode && temp_warning_det && !battery_por && !logic_supply_fail
         |=> ##1 diagnostic_register_zero.temp_prewarning_flag;
   endproperty
   a_prewarn: assert property (p_prewarn) else $error("prewarning not latched");
   property p_short_latch;
      short_supply_det[2] && gate_low[2] && !short_detect_disable[2] && !high_side_output[2]
         && !battery_por |=> ##1 (diagnostic_register_zero.short_to_supply_flag[2]
         && diagnostic_register_zero.open_load_off_flag[2]);
   endproperty
   a_short_latch: assert property (p_short_latch) else $error("short flags not latched");
endmodule
bind fault_diag_autoretry fault_diag_autoretry_sva u_sva (
   .clk(clk), .rst_b(rst_b), .normal_mode(normal_mode), .battery_uv(battery_uv),
   .battery_por(battery_por), .logic_supply_fail(logic_supply_fail), .clamp_det(clamp_det),
   .temp_warning_det(temp_warning_det), .short_supply_det(short_supply_det),
   .gate_low(gate_low), .short_detect_disable(short_detect_disable),
   .high_side_output(high_side_output), .inrush_profile_restart(inrush_profile_restart),
   .fault_flag_n(fault_flag_n), .diagnostic_register_zero(diagnostic_register_zero),
   .analog_feedback_out(analog_feedback_out), .regs_cleared(regs_cleared));

// [bench/mcu_status_reader.sv]
// Controller model that issues status reads and keeps what was shifted out
`timescale 1ns/1ps
module mcu_status_reader
   import fault_diag_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic          read_req,
   input  wire fault_report_s report,
   output logic               status_read,
   output fault_report_s      captured
);
   // One transfer per request; the report is taken before the clear lands
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_read <= 1'b0;
         captured    <= '0;
      end else begin
         status_read <= read_req && !status_read;
         if (status_read) begin
            captured <= report;
         end
      end
   end
endmodule

// [bench/fault_diag_autoretry_test.sv]
// Self-checking bench for the fault and diagnostic manager
`timescale 1ns/1ps
`include "fault_diag_defs.svh"
module fault_diag_autoretry_test;
   import fault_diag_pkg::*;
   localparam int T_AUTO = 8;
   logic clk = 1'b0, rst_b = 1'b0, status_read;
   logic [3:0] output_cmd = 4'h0, direct_input = 4'h0, oc_det = 4'h0, ot_det = 4'h0;
   logic [3:0] sev_det = 4'h0, short_det = 4'h0, gate_low = 4'h0, olf_det = 4'h0;
   logic [3:0] oln_det = 4'h0, short_dis = 4'h0, olf_dis = 4'h0, oln_dis = 4'h0;
   logic [3:0] led_sel = 4'h0, retry_dis = 4'h0, hs_out, restart;
   logic [6:0] duty = 7'h7F;
   logic normal_mode = 1'b1, ext_mode = 1'b0, battery_uv = 1'b0, battery_por = 1'b0;
   logic vdd_fail = 1'b0, vdd_fail_en = 1'b0, ov_det = 1'b0, ov_dis = 1'b0, clamp = 1'b0;
   logic temp_warn = 1'b0, read_req = 1'b0, fault_n, cleared;
   feedback_cfg_s fb_cfg = '0;
   fault_report_s report, captured;
   feedback_route_s fb_out;
   int err_total = 0, n_checks = 0, n_restart = 0;
   fault_diag_autoretry #(.T_AUTO_CYC(T_AUTO), .LED_CHECK_PERIOD_CYC(T_AUTO)) dut (
      .clk(clk), .rst_b(rst_b), .output_cmd(output_cmd), .direct_input(direct_input),
      .duty_ch0(duty), .duty_ch1(duty), .duty_ch2(duty), .duty_ch3(duty),
      .normal_mode(normal_mode), .extended_mode(ext_mode), .battery_uv(battery_uv),
      .battery_por(battery_por), .logic_supply_fail(vdd_fail), .supply_fail_enable(vdd_fail_en),
      .overvoltage_det(ov_det), .overvoltage_disable(ov_dis), .clamp_det(clamp),
      .temp_warning_det(temp_warn), .overcurrent_det(oc_det), .overtemp_det(ot_det),
      .severe_short_det(sev_det), .short_supply_det(short_det), .gate_low(gate_low),
      .open_load_off_det(olf_det), .open_load_on_det(oln_det), .short_detect_disable(short_dis),
      .open_load_off_disable(olf_dis), .open_load_on_disable(oln_dis),
      .led_open_load_select(led_sel), .retry_disable(retry_dis), .feedback_cfg(fb_cfg),
      .status_read(status_read), .high_side_output(hs_out), .inrush_profile_restart(restart),
      .fault_flag_n(fault_n), .diagnostic_register_zero(report), .analog_feedback_out(fb_out),
      .regs_cleared(cleared));
   mcu_status_reader mcu (.clk(clk), .rst_b(rst_b), .read_req(read_req), .report(report),
      .status_read(status_read), .captured(captured));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) n_restart <= 0;
      else if (restart[0] === 1'b1) n_restart <= n_restart + 1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic look(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic rst_all;
      @(posedge clk) rst_b <= 1'b0;
      @(posedge clk);
      @(posedge clk) rst_b <= 1'b1;
   endtask
   task automatic read_status;
      @(posedge clk) read_req <= 1'b1;
      @(posedge clk) read_req <= 1'b0;
      look(3);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_retry;
      int k, i;
      @(posedge clk) output_cmd <= 4'h1;
      for (k = 0; k < 17; k++) begin
         for (i = 0; i < 60 && hs_out[0] !== 1'b1; i++) @(negedge clk);
         chk(hs_out[0], 1'b1, "output back on");
         @(posedge clk) oc_det <= 4'h1;
         @(posedge clk) oc_det <= 4'h0;
         read_status;
      end
      look(4 * T_AUTO);
      chk(hs_out[0], 1'b0, "still off after limit");
      chk(n_restart, 17, "inrush restarts");
      @(posedge clk) output_cmd <= 4'h0;
      look(2);
      @(posedge clk) output_cmd <= 4'h1;
      look(4);
      chk(hs_out[0], 1'b1, "command toggle unlocks");
      @(posedge clk) output_cmd <= 4'h0;
      $display("retry test done");
   endtask
   task automatic t_uv;
      @(posedge clk) battery_uv <= 1'b1;
      look(2);
      chk({hs_out, fault_n, report.undervoltage_flag}, 6'h01, "uv with command off");
      @(posedge clk) battery_uv <= 1'b0;
      look(3);
      chk({fault_n, report.undervoltage_flag}, 2'b11, "pin high, bit kept");
      read_status;
      chk(captured.undervoltage_flag, 1'b1, "uv shifted out");
      chk(report.undervoltage_flag, 1'b0, "uv cleared by read");
      @(posedge clk) output_cmd <= 4'h1;
      look(3);
      @(posedge clk) battery_uv <= 1'b1;
      look(2);
      chk(hs_out, 4'h0, "uv turns off");
      @(posedge clk) battery_uv <= 1'b0;
      look(2);
      chk(fault_n, 1'b0, "pin held with command on");
      // Controller drops its commands before the supply reset
      @(posedge clk) output_cmd <= 4'h0;
      @(posedge clk) battery_por <= 1'b1;
      look(3);
      chk({cleared, hs_out}, 5'h10, "supply reset");
      chk(report, '0, "faults wiped");
      @(posedge clk) battery_por <= 1'b0;
      $display("undervoltage test done");
   endtask
   task automatic t_short_clamp;
      @(posedge clk) short_dis <= 4'h4;
      short_det <= 4'h4;
      gate_low <= 4'hF;
      look(3);
      chk(report.short_to_supply_flag[2], 1'b0, "disabled short");
      @(posedge clk) short_dis <= 4'h0;
      look(3);
      chk(fault_n, 1'b0, "short on pin");
      chk({report.short_to_supply_flag[2], report.open_load_off_flag[2]}, 2'b11, "short");
      @(posedge clk) short_det <= 4'h0;
      look(2);
      chk(fault_n, 1'b1, "pin follows short");
      read_status;
      chk(captured.short_to_supply_flag[2], 1'b1, "short shifted out");
      chk(report.short_to_supply_flag[2], 1'b0, "short cleared by read");
      @(posedge clk) clamp <= 1'b1;
      look(1);
      chk(hs_out, 4'hF, "clamp forces on");
      @(posedge clk) clamp <= 1'b0;
      gate_low <= 4'h0;
      look(2);
      $display("short and clamp test done");
   endtask
   task automatic t_open_on_warn;
      @(posedge clk) output_cmd <= 4'h2;
      temp_warn <= 1'b1;
      @(posedge clk) temp_warn <= 1'b0;
      oln_det <= 4'h2;
      look(3);
      chk({hs_out[1], fault_n, report.open_load_on_flag[1]}, 3'h7, "open on");
      chk(report.temp_prewarning_flag, 1'b1, "prewarning");
      @(posedge clk) oln_det <= 4'h0;
      read_status;
      chk({report.open_load_on_flag[1], report.temp_prewarning_flag}, 2'b00, "read");
      @(posedge clk) oln_dis <= 4'h2;
      oln_det <= 4'h2;
      look(3);
      chk(report.open_load_on_flag[1], 1'b0, "open on disabled");
      @(posedge clk) led_sel <= 4'h2;
      oln_dis <= 4'h0;
      duty <= 7'h7E;
      look(20);
      chk(report.open_load_on_flag[1], 1'b0, "led part on");
      @(posedge clk) duty <= 7'h7F;
      look(20);
      chk(report.open_load_on_flag[1], 1'b1, "led open");
      @(posedge clk) oln_det <= 4'h0;
      oln_dis <= 4'h0;
      output_cmd <= 4'h0;
      $display("open load and prewarning test done");
   endtask
   task automatic t_feedback;
      @(posedge clk) fb_cfg <= '{1'b0, 1'b1, 2'h0, 4'h0};
      output_cmd <= 4'h1;
      look(3);
      chk({fb_out.source, fb_out.channel}, {`FD_FB_SEL_CURR, 2'h0}, "recopy on");
      @(posedge clk) output_cmd <= 4'h0;
      look(3);
      chk(fb_out.source == `FD_FB_SEL_CURR, 1'b0, "no recopy while off");
      @(posedge clk) output_cmd <= 4'h1;
      normal_mode <= 1'b0;
      look(3);
      chk(fb_out.source == `FD_FB_SEL_CURR, 1'b0, "no recopy in fail-safe");
      @(posedge clk) normal_mode <= 1'b1;
      fb_cfg <= '{1'b1, 1'b0, 2'h0, 4'h0};
      look(3);
      chk(fb_out.source, `FD_FB_SEL_TEMP, "temperature routed");
      @(posedge clk) output_cmd <= 4'h0;
      $display("feedback test done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_all;
      t_retry;
      rst_all;
      t_uv;
      rst_all;
      t_short_clamp;
      rst_all;
      t_open_on_warn;
      rst_all;
      t_feedback;
      end_of_test;
   end
   // About 400 cycles are needed; allow fifty times that before giving up
   initial begin
      #200000;
      err_total++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test;
   end
endmodule
